// file: design/ppqi_regs.sv
// Policing control, port pointer and transmit queue index registers
// for one switch port, with the drop and color statistics counters.
// Assumes an AXI4-Lite master on aclk and a policing datapath that
// consumes the registered control outputs and reports packet events.
//
// Notes on behaviour
// - Enable bit turns policing and WRED on
// - Mode bit: one blind, zero color aware
// - Port-based bit keeps per port-queue state
// - Shared mode uses port zero settings everywhere
// - Type field picks red, yellow, green, dropped
// - Dropped-color bit counts only dropped colored packets
// - Drop-all drops everything above max threshold
// - SRP packets droppable only when bit set
// - Non-IP frames get default color, resets 01
// - Mark bit writes metered color into DSCP
// - Remap bit remaps DSCP color when aware
// - Queue index selects egress queue for access
// - Index byte also writable at last byte
// - Port selector picks port for indirect access
// - Queue selector picks queue for indirect access
`timescale 1ns/100ps
`include "ppqi_consts.svh"
module ppqi_regs #(
  parameter int PORTS = 3,
  parameter int CW = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ev_valid,
  input wire logic [2:0] ev_port,
  input wire logic [1:0] ev_queue,
  input wire logic [1:0] ev_color,
  input wire logic ev_dropped,
  input wire logic [2:0] dp_port,
  output logic pol_active_q,
  output logic color_blind_q,
  output logic color_aware_q,
  output logic per_port_q,
  output logic [2:0] pol_port_q,
  output logic drop_all_q,
  output logic srp_drop_ok_q,
  output logic remap_en_q,
  output logic mark_en_q,
  output logic [1:0] non_ip_default_color_q,
  output logic [1:0] txq_index_q
);

  localparam int MAW = 6;
  localparam int DEPTH = PORTS * 16;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [31:0] ctl_q;
  logic [31:0] ptr_q;
  logic [15:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_got_q;
  logic w_got_q;
  logic [15:0] araddr_q;
  ppqi_pkg::ppqi_rd_e rd_q;
  ppqi_pkg::ppqi_rd_e rd_d;
  logic [CW-1:0] stat_rd_data;

  // ----------------------------------------------------------------
  // Write channel decode
  // ----------------------------------------------------------------
  // A write commits once both address and data are held
  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs = s_axi_wvalid & s_axi_wready;
  wire b_hs = s_axi_bvalid & s_axi_bready;
  wire wr_fire = aw_got_q & w_got_q & ~s_axi_bvalid;
  wire wr_ctl = wr_fire & (awaddr_q[15:2] == `PPQI_CTL_OFS >> 2);
  wire wr_ptr = wr_fire & (awaddr_q[15:2] == `PPQI_PTR_OFS >> 2);
  wire wr_txq = wr_fire & (awaddr_q[15:2] == `PPQI_TXQ_OFS >> 2);
  wire wr_stat = wr_fire & (awaddr_q[15:2] == `PPQI_STAT_OFS >> 2);
  wire wr_hit = wr_ctl | wr_ptr | wr_txq | wr_stat;
  wire aw_got_d = aw_hs | (aw_got_q & ~b_hs);
  wire w_got_d = w_hs | (w_got_q & ~b_hs);
  wire bvalid_d = wr_fire | (s_axi_bvalid & ~b_hs);

  // Byte enables expanded to a bit mask
  wire [31:0] strb_mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                           {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  // Only writable fields take data; reserved bits stay zero
  wire [31:0] ctl_m = strb_mask & `PPQI_CTL_WMASK;
  wire [31:0] ptr_m = strb_mask & `PPQI_PTR_WMASK;
  wire [31:0] ctl_d = (ctl_q & ~ctl_m) | (wdata_q & ctl_m);
  wire [31:0] ptr_d = (ptr_q & ~ptr_m) | (wdata_q & ptr_m);
  // Index byte reachable on lane 0 or aliased on lane 3
  wire [1:0] txq_d = wstrb_q[0] ? wdata_q[1:0] :
                     wstrb_q[3] ? wdata_q[25:24] : txq_index_q;

  // ----------------------------------------------------------------
  // Write channel handshake
  // ----------------------------------------------------------------
  // Ready held low while a captured item waits for its partner
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PPQI_RESP_OKAY;
    end
    else
    begin
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      s_axi_awready <= ~aw_got_d;
      s_axi_wready <= ~w_got_d;
      s_axi_bvalid <= bvalid_d;
      if (wr_fire)
        s_axi_bresp <= wr_hit ? `PPQI_RESP_OKAY : `PPQI_RESP_SLVERR;
    end
  end

  // Payload capture, no reset needed on data
  always_ff @(posedge aclk)
  begin
    if (aw_hs)
      awaddr_q <= s_axi_awaddr;
    if (w_hs)
    begin
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end
  end

  // ----------------------------------------------------------------
  // Software-visible registers
  // ----------------------------------------------------------------
  // Statistics register is read only; writes there are ignored
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctl_q <= `PPQI_CTL_RESET;
      ptr_q <= `PPQI_PTR_RESET;
      txq_index_q <= 2'h0;
    end
    else
    begin
      if (wr_ctl)
        ctl_q <= ctl_d;
      if (wr_ptr)
        ptr_q <= ptr_d;
      if (wr_txq)
        txq_index_q <= txq_d;
    end
  end

  // ----------------------------------------------------------------
  // Control decode toward the policing datapath
  // ----------------------------------------------------------------
  // Every feature except the port-based bit, port selection and non-IP default color is gated by the enable
  wire en = ctl_q[`PPQI_CTL_EN];
  wire blind = ctl_q[`PPQI_CTL_BLIND];
  wire aware = en & ~blind;
  wire perport = ctl_q[`PPQI_CTL_PERPORT];
  // Shared mode points every port at the port zero rate settings
  wire [2:0] pol_port_d = perport ? dp_port : 3'h0;

  // Outputs registered so the datapath sees stable levels
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pol_active_q <= 1'b0;
      color_blind_q <= 1'b0;
      color_aware_q <= 1'b0;
      per_port_q <= 1'b0;
      pol_port_q <= 3'h0;
      drop_all_q <= 1'b0;
      srp_drop_ok_q <= 1'b0;
      remap_en_q <= 1'b0;
      mark_en_q <= 1'b0;
      non_ip_default_color_q <= 2'h1;
    end
    else
    begin
      pol_active_q <= en;
      color_blind_q <= en & blind;
      color_aware_q <= aware;
      per_port_q <= perport;
      pol_port_q <= pol_port_d;
      drop_all_q <= en & ctl_q[`PPQI_CTL_DROPALL];
      srp_drop_ok_q <= en & ctl_q[`PPQI_CTL_SRP];
      remap_en_q <= aware & ctl_q[`PPQI_CTL_REMAP];
      mark_en_q <= en & ctl_q[`PPQI_CTL_MARK];
      non_ip_default_color_q <= ctl_q[`PPQI_CTL_NCOL_LO +: 2];
    end
  end

  // ----------------------------------------------------------------
  // Statistics counting
  // ----------------------------------------------------------------
  // Counters only move while policing runs; colored events may be
  // restricted to drops, dropped colored events on valid ports always hit the drop counter
  wire ev_ok = ev_valid & en & (ev_port < 3'(PORTS)) & (ev_color != 2'h0);
  wire inc_color = ev_ok & (~ctl_q[`PPQI_CTL_DCOLOR] | ev_dropped);
  wire inc_drop = ev_ok & ev_dropped;
  wire [MAW-1:0] color_idx = {ev_port[1:0], ev_queue, ev_color};
  wire [MAW-1:0] drop_idx = {ev_port[1:0], ev_queue, 2'h0};
  // Port and queue selectors plus type choose the readable counter
  wire [1:0] stat_type = ctl_q[`PPQI_CTL_TYPE_LO +: 2];
  wire [MAW-1:0] stat_idx = {ptr_q[`PPQI_PTR_PORT_LO +: 2],
                             ptr_q[`PPQI_PTR_QUEUE_LO +: 2], stat_type};
  wire stat_port_ok = ptr_q[`PPQI_PTR_PORT_LO +: 3] < 3'(PORTS);

  ppqi_stat_mem #(
    .DEPTH(DEPTH),
    .AW(MAW),
    .CW(CW)
  ) u_stat (
    .aclk(aclk),
    .aresetn(aresetn),
    .inc_a_en(inc_color),
    .inc_a_idx(color_idx),
    .inc_b_en(inc_drop),
    .inc_b_idx(drop_idx),
    .rd_idx(stat_idx),
    .rd_data_q(stat_rd_data)
  );

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  // Every read takes one wait cycle so the counter store can answer
  wire ar_hs = s_axi_arvalid & s_axi_arready;
  wire r_hs = s_axi_rvalid & s_axi_rready;
  wire rd_ctl = araddr_q[15:2] == `PPQI_CTL_OFS >> 2;
  wire rd_ptr = araddr_q[15:2] == `PPQI_PTR_OFS >> 2;
  wire rd_txq = araddr_q[15:2] == `PPQI_TXQ_OFS >> 2;
  wire rd_stat = araddr_q[15:2] == `PPQI_STAT_OFS >> 2;
  wire rd_hit = rd_ctl | rd_ptr | rd_txq | rd_stat;
  wire [31:0] stat_word = stat_port_ok ? 32'(stat_rd_data) : 32'h0;
  // Byte read at the last lane sees the index there; word reads stay clean
  wire [31:0] txq_word = (araddr_q[1:0] == 2'h3) ? {6'h0, txq_index_q, 24'h0} :
                         {30'h0, txq_index_q};
  // Reserved bits come back as zero from every register
  wire [31:0] rd_word = rd_ctl ? (ctl_q & `PPQI_CTL_WMASK) :
                        rd_ptr ? (ptr_q & `PPQI_PTR_WMASK) :
                        rd_txq ? txq_word :
                        rd_stat ? stat_word : 32'h0;

  // Read sequencing
  always_comb
  begin
    rd_d = rd_q;
    case (rd_q)
      ppqi_pkg::PPQI_RD_IDLE:
        if (ar_hs)
          rd_d = ppqi_pkg::PPQI_RD_WAIT;
      ppqi_pkg::PPQI_RD_WAIT:
        rd_d = ppqi_pkg::PPQI_RD_RESP;
      ppqi_pkg::PPQI_RD_RESP:
        if (r_hs)
          rd_d = ppqi_pkg::PPQI_RD_IDLE;
      default:
        rd_d = ppqi_pkg::PPQI_RD_IDLE;
    endcase
  end

  // Read state and answer registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_q <= ppqi_pkg::PPQI_RD_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `PPQI_RESP_OKAY;
      araddr_q <= 16'h0;
    end
    else
    begin
      rd_q <= rd_d;
      s_axi_arready <= rd_d == ppqi_pkg::PPQI_RD_IDLE;
      s_axi_rvalid <= rd_d == ppqi_pkg::PPQI_RD_RESP;
      if (ar_hs)
        araddr_q <= s_axi_araddr;
      if (rd_q == ppqi_pkg::PPQI_RD_WAIT)
      begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? `PPQI_RESP_OKAY : `PPQI_RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  wr_resp_follows_a: assert property (
    wr_fire |=> s_axi_bvalid &&
      (s_axi_bresp == ($past(wr_hit) ? `PPQI_RESP_OKAY : `PPQI_RESP_SLVERR)))
    else $error("Write response did not follow commit");
  rd_two_cycle_a: assert property (
    ar_hs |=> !s_axi_rvalid ##1 s_axi_rvalid)
    else $error("Read answer not two cycles after address");
  bypass_all_a: assert property (
    !en |=> !pol_active_q && !drop_all_q && !mark_en_q && !srp_drop_ok_q)
    else $error("Disabled policing left a feature active");
  mode_select_a: assert property (
    en ##1 1'b1 |-> color_blind_q == $past(blind) && color_aware_q == !$past(blind))
    else $error("Police mode output wrong");
  shared_port_a: assert property (
    !perport |=> pol_port_q == 3'h0)
    else $error("Shared policing did not use port zero");
  reserved_zero_a: assert property (
    s_axi_rvalid && s_axi_rresp == `PPQI_RESP_OKAY && rd_ctl
      |-> s_axi_rdata[31:12] == 20'h0)
    else $error("Reserved control bits read nonzero");
  byte_alias_a: assert property (
    wr_txq && wstrb_q == 4'h8 |=> txq_index_q == $past(wdata_q[25:24]))
    else $error("Index byte alias write lost");
  drop_color_a: assert property (
    ev_ok && ctl_q[`PPQI_CTL_DCOLOR] && !ev_dropped |-> !inc_color)
    else $error("Undropped packet counted in dropped-color mode");
  srp_gate_a: assert property (
    !ctl_q[`PPQI_CTL_SRP] |=> !srp_drop_ok_q)
    else $error("SRP drop allowed with bit clear");
  remap_aware_a: assert property (
    blind |=> !remap_en_q)
    else $error("Remap active in color blind mode");

  wr_done_c: cover property (wr_ctl ##[1:4] b_hs);
  stat_read_c: cover property (ar_hs ##2 r_hs && rd_stat);
  alias_write_c: cover property (wr_txq && wstrb_q == 4'h8);
  count_event_c: cover property (inc_color && inc_drop);

endmodule : ppqi_regs

// file: design/ppqi_stat_mem.sv
// Statistics counter store: one counter per port, queue and type.
// Assumes the two increment indexes never collide in one cycle.
`timescale 1ns/100ps
module ppqi_stat_mem #(
  parameter int DEPTH = 48,
  parameter int AW = 6,
  parameter int CW = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic inc_a_en,
  input wire logic [AW-1:0] inc_a_idx,
  input wire logic inc_b_en,
  input wire logic [AW-1:0] inc_b_idx,
  input wire logic [AW-1:0] rd_idx,
  output logic [CW-1:0] rd_data_q
);

  // ----------------------------------------------------------------
  // Counter array
  // ----------------------------------------------------------------
  logic [CW-1:0] cnt_q [DEPTH];

  // Counters saturate-free: wrap is acceptable for statistics
  always_ff @(posedge aclk)
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      if (!aresetn)
        cnt_q[i] <= '0;
      else if ((inc_a_en && (int'(inc_a_idx) == i)) ||
               (inc_b_en && (int'(inc_b_idx) == i)))
        cnt_q[i] <= cnt_q[i] + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  // Registered read; out of range indexes read zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rd_data_q <= '0;
    else if (int'(rd_idx) < DEPTH)
      rd_data_q <= cnt_q[rd_idx];
    else
      rd_data_q <= '0;
  end

endmodule : ppqi_stat_mem

// file: dv/ppqi_tb.sv
// Bench for the policing and queue index register block.
// Assumes one block, driven over AXI4-Lite, the event inputs and dp_port only.
`timescale 1ns/100ps
`include "ppqi_consts.svh"
module testbench;
  logic aclk;
  logic aresetn;
  logic [15:0] awaddr;
  logic awvalid;
  logic awready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wvalid;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  logic [15:0] araddr;
  logic arvalid;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready;
  logic ev_valid;
  logic [2:0] ev_port;
  logic [1:0] ev_queue;
  logic [1:0] ev_color;
  logic ev_dropped;
  logic [2:0] dp_port;
  wire [10:0] outs;
  logic [2:0] pol_port;
  logic [1:0] txq;
  logic [31:0] rd;
  logic [1:0] rsp;
  int bad_count;
  int cmp_count;
  int cyc;

  ppqi_regs dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ev_valid(ev_valid), .ev_port(ev_port), .ev_queue(ev_queue),
    .ev_color(ev_color), .ev_dropped(ev_dropped), .dp_port(dp_port),
    .pol_active_q(outs[10]), .color_blind_q(outs[9]), .color_aware_q(outs[8]),
    .per_port_q(outs[7]), .pol_port_q(pol_port), .drop_all_q(outs[6]),
    .srp_drop_ok_q(outs[5]), .remap_en_q(outs[3]), .mark_en_q(outs[4]),
    .non_ip_default_color_q(outs[1:0]), .txq_index_q(txq));
  assign outs[2] = 1'b0;

  // ----------------------------------------------------------------
  // Clock, timeout and verdict
  // ----------------------------------------------------------------
  always #2.5 aclk = ~aclk;

  // Generous ceiling; the sequence needs well under a thousand cycles
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count = bad_count + 1;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
      bad_count = bad_count + 1;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // ----------------------------------------------------------------
  // Bus tasks; each channel held until its own ready
  // ----------------------------------------------------------------
  task automatic axi_write(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
    output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1)
      begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1)
      begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_read

  // Write the control word and let the registered outputs settle
  task automatic set_ctl(input logic [31:0] v);
    axi_write(`PPQI_CTL_OFS, v, 4'hf, rsp);
    check("ctl bresp", rsp, `PPQI_RESP_OKAY);
    repeat (3) @(posedge aclk);
  endtask : set_ctl

  task automatic ev(input logic [1:0] q, input logic [1:0] c, input logic dr);
    @(posedge aclk);
    ev_valid <= 1'b1;
    ev_port <= 3'h1;
    ev_queue <= q;
    ev_color <= c;
    ev_dropped <= dr;
    @(posedge aclk);
    ev_valid <= 1'b0;
  endtask : ev

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  logic [31:0] exp_st [4];
  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, ev_valid, ev_port, ev_queue, ev_color, ev_dropped} = '0;
    dp_port = 3'h2;
    bad_count = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    #1;
    check("reset outputs", outs, 11'h001);
    axi_read(`PPQI_CTL_OFS, rd, rsp);
    check("ctl reset", rd, `PPQI_CTL_RESET);
    axi_read(`PPQI_TXQ_OFS, rd, rsp);
    check("txq reset", rd, 32'h00000000);
    axi_read(16'h1a00, rd, rsp);
    check("unmapped rresp", rsp, `PPQI_RESP_SLVERR);
    check("unmapped rdata", rd, 32'h00000000);
    axi_write(16'h1a00, 32'h0000ffff, 4'hf, rsp);
    check("unmapped bresp", rsp, `PPQI_RESP_SLVERR);
    // All bits set, reserved ones must vanish
    set_ctl(32'hffffffff);
    axi_read(`PPQI_CTL_OFS, rd, rsp);
    check("ctl mask", rd, 32'h00000fff);
    #1;
    check("blind outputs", outs, 11'h6f3);
    check("per port sel", pol_port, 3'h2);
    set_ctl(32'h00000ffe);
    #1;
    check("bypass outputs", outs, 11'h083);
    set_ctl(32'h00000009);
    #1;
    check("aware outputs", outs, 11'h508);
    check("shared sel", pol_port, 3'h0);
    // Queue index, byte lane zero and byte lane three
    axi_write(`PPQI_TXQ_OFS, 32'h000000ff, 4'h1, rsp);
    axi_read(`PPQI_TXQ_OFS, rd, rsp);
    check("txq mask", rd, 32'h00000003);
    axi_write(`PPQI_TXQ_OFS, 32'h02000000, 4'h8, rsp);
    repeat (2) @(posedge aclk);
    check("txq byte", txq, 2'h2);
    axi_read(`PPQI_TXQ_OFS + 16'h3, rd, rsp);
    check("txq byte read", rd, 32'h02000000);
    // Statistics for port 1 queue 2
    axi_write(`PPQI_PTR_OFS, 32'hffff0002, 4'hf, rsp);
    axi_read(`PPQI_PTR_OFS, rd, rsp);
    check("ptr mask", rd, 32'h00070002);
    axi_write(`PPQI_PTR_OFS, 32'h00010002, 4'hf, rsp);
    set_ctl(32'h00000001);
    ev(2'h2, 2'h1, 1'b0);
    ev(2'h2, 2'h1, 1'b0);
    ev(2'h2, 2'h3, 1'b1);
    ev(2'h1, 2'h2, 1'b0);
    exp_st = '{32'h1, 32'h2, 32'h0, 32'h1};
    for (int t = 0; t < 4; t++)
    begin
      set_ctl(32'h00000001 | (t << 8));
      axi_read(`PPQI_STAT_OFS, rd, rsp);
      check("stat type", rd, exp_st[t]);
    end
    axi_write(`PPQI_STAT_OFS, 32'h0000ffff, 4'hf, rsp);
    check("stat wr bresp", rsp, `PPQI_RESP_OKAY);
    // Only dropped packets count per color now
    set_ctl(32'h00000901);
    ev(2'h2, 2'h1, 1'b0);
    ev(2'h2, 2'h1, 1'b1);
    axi_read(`PPQI_STAT_OFS, rd, rsp);
    check("dropped green", rd, 32'h00000003);
    // Disabled: no counting at all
    set_ctl(32'h00000000);
    ev(2'h2, 2'h1, 1'b1);
    set_ctl(32'h00000001);
    axi_read(`PPQI_STAT_OFS, rd, rsp);
    check("drop count", rd, 32'h00000002);
    axi_write(`PPQI_PTR_OFS, 32'h00010001, 4'hf, rsp);
    set_ctl(32'h00000201);
    axi_read(`PPQI_STAT_OFS, rd, rsp);
    check("queue sel", rd, 32'h00000001);
    give_verdict();
  end
endmodule : testbench

// file: inc/ppqi_consts.svh
// Constants for the port policing and queue index register block.
// Assumes one copy per switch port; offsets shown are for port 1.
`ifndef PPQI_CONSTS_SVH
`define PPQI_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PPQI_PTR_OFS 16'h1804
`define PPQI_CTL_OFS 16'h180c
`define PPQI_STAT_OFS 16'h1810
`define PPQI_TXQ_OFS 16'h1900

// ----------------------------------------------------------------
// Field positions in the policing control register
// ----------------------------------------------------------------
`define PPQI_CTL_EN 0
`define PPQI_CTL_BLIND 1
`define PPQI_CTL_SRP 2
`define PPQI_CTL_REMAP 3
`define PPQI_CTL_MARK 4
`define PPQI_CTL_NCOL_LO 5
`define PPQI_CTL_PERPORT 7
`define PPQI_CTL_TYPE_LO 8
`define PPQI_CTL_DROPALL 10
`define PPQI_CTL_DCOLOR 11

// Port selector and queue selector positions
`define PPQI_PTR_PORT_LO 16
`define PPQI_PTR_QUEUE_LO 0

// ----------------------------------------------------------------
// Writable masks and reset values
// ----------------------------------------------------------------
`define PPQI_CTL_WMASK 32'h00000fff
`define PPQI_PTR_WMASK 32'h00070003
`define PPQI_TXQ_WMASK 32'h00000003
`define PPQI_CTL_RESET 32'h00000020
`define PPQI_PTR_RESET 32'h00000000
`define PPQI_TXQ_RESET 32'h00000000

// Bus responses
`define PPQI_RESP_OKAY 2'h0
`define PPQI_RESP_SLVERR 2'h2

`endif

// file: inc/ppqi_pkg.sv
// Types shared by the policing and queue index register block.
// Constants live in ppqi_consts.svh; this package holds types only.
package ppqi_pkg;

  // ----------------------------------------------------------------
  // Read channel states, Gray coded along idle-wait-respond
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PPQI_RD_IDLE = 2'h0,
    PPQI_RD_WAIT = 2'h1,
    PPQI_RD_RESP = 2'h3
  } ppqi_rd_e;

  // Statistics counter selection
  typedef enum logic [1:0] {
    PPQI_ST_DROP = 2'h0,
    PPQI_ST_GREEN = 2'h1,
    PPQI_ST_YELLOW = 2'h2,
    PPQI_ST_RED = 2'h3
  } ppqi_stat_e;

endpackage : ppqi_pkg
